// ### adc_cfg_params.svh
`ifndef ADC_CFG_PARAMS_SVH
`define ADC_CFG_PARAMS_SVH
`define ADDR_SOFT_RESET 8'h00
`define ADDR_SWING 8'h01
`define ADDR_PERF_ONE 8'h03
`define ADDR_GAIN_PAT 8'h25
`define ADDR_DRIVE 8'h26
`define ADDR_FORMAT 8'h3D
`define ADDR_CUSTOM_HI 8'h3F
`define ADDR_CUSTOM_LO 8'h40
`define ADDR_IF_RISE 8'h41
`define ADDR_FALL_STBY 8'h42
`define ADDR_PDN 8'h43
`define ADDR_PERF_TWO 8'h4A
`define ADDR_PEDESTAL 8'hBF
`define ADDR_OFFS_LOOP 8'hCF
`define ADDR_SLOW_RATE 8'hDF
`define REG_RESET_VALUE 8'h00
`define BIT_READBACK 0
`define BIT_SOFT_RESET 1
`define WORD_BITS 16
`define SWING_DEFAULT 6'h00
`define RAMP_DIV 4
`define TOGGLE_A 12'h555
`define TOGGLE_B 12'hAAA
`define FMT_STRAP 2'h0
`define FMT_TWOS 2'h2
`define FMT_OFFSET 2'h3
`endif

// ### adc_cfg_pkg.sv
package adc_cfg_pkg;
    typedef enum logic [2:0] {
        pat_normal, pat_zeros, pat_ones, pat_toggle,
        pat_ramp, pat_custom, pat_unused_a, pat_unused_b
    } pattern_e;
endpackage

// ### adc_config_register_bank.sv
// Notes on behaviour
// - one write updates all fields of a register
// - soft reset bit restores defaults, self-clears
// - readback bit selects shared pin function
// - swing code picks differential swing level
// - swing code applies only with override enabled
// - gain field, half-dB steps, 0 to 6 dB
// - gain bypass; gain needs fast path disabled
// - patterns: normal, all zeros, all ones
// - toggle pattern alternates 555h and AAAh
// - ramp advances one code per four samples
// - custom pattern from 3Fh and 40h
// - clock driver strength double select
// - data driver strength double select
// - 16-bit words shifted on falling serial edge
// - readback mode blocks writes except 00h
// - number format from strap or forced
`timescale 1ns/1ns
`include "adc_cfg_params.svh"
module adc_config_register_bank #(
    parameter int DATA_WIDTH = 12
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic serial_select_n,
    input wire logic serial_data_pin,
    input wire logic overvoltage,
    input wire logic format_strap_pin,
    input wire logic [DATA_WIDTH-1:0] conv_data,
    output logic overrange_readback_pin,
    output logic [DATA_WIDTH-1:0] sample_out,
    output logic [5:0] swing_code,
    output logic clock_driver_double,
    output logic data_driver_double,
    output logic [3:0] gain_code,
    output logic gain_active,
    output logic twos_complement,
    output logic [1:0] perf_boost_one,
    output logic perf_boost_two,
    output logic [7:0] interface_and_clock_rise,
    output logic [7:0] clock_fall_and_standby,
    output logic [7:0] power_down_ctrl,
    output logic [7:0] offset_pedestal_ctrl,
    output logic [7:0] offset_loop_ctrl,
    output logic [7:0] slow_rate_ctrl
);
    // register storage
    logic [7:0] soft_reset_and_readback, output_swing_ctrl;
    logic [7:0] perf_mode_one_ctrl, gain_and_pattern_ctrl;
    logic [7:0] output_drive_strength, format_and_offset_ctrl;
    logic [7:0] custom_word_high, custom_word_low, perf_mode_two_ctrl;
    logic [7:0] reg_if, reg_fall, reg_pdn, reg_ped, reg_loop, reg_slow;
    // serial interface state
    logic clk_s1, clk_s2, clk_s3, sel_s1, sel_s2, dat_s1, dat_s2;
    logic [3:0] bit_cnt;
    logic [14:0] shift;
    logic [3:0] next_bit_cnt;
    logic [14:0] next_shift;
    logic wr_stb;
    logic [15:0] wr_word;
    logic [7:0] rd_shift, next_rd_shift;
    // pattern state
    logic [1:0] ramp_div;
    logic [DATA_WIDTH-1:0] ramp_val;
    logic toggle_ph;
    logic [1:0] next_ramp_div;
    logic [DATA_WIDTH-1:0] next_ramp_val;
    logic next_toggle_ph;
    logic [DATA_WIDTH-1:0] next_sample;
    logic fast_path_disable;
    logic swing_override_enable;
    logic next_pin, next_gain_active, next_twos;
    logic [5:0] next_swing;

    function automatic logic [7:0] read_reg(input logic [7:0] a);
        unique case (a)
            `ADDR_SWING: read_reg = output_swing_ctrl;
            `ADDR_PERF_ONE: read_reg = perf_mode_one_ctrl;
            `ADDR_GAIN_PAT: read_reg = gain_and_pattern_ctrl;
            `ADDR_DRIVE: read_reg = output_drive_strength;
            `ADDR_FORMAT: read_reg = format_and_offset_ctrl;
            `ADDR_CUSTOM_HI: read_reg = custom_word_high;
            `ADDR_CUSTOM_LO: read_reg = custom_word_low;
            `ADDR_IF_RISE: read_reg = reg_if;
            `ADDR_FALL_STBY: read_reg = reg_fall;
            `ADDR_PDN: read_reg = reg_pdn;
            `ADDR_PERF_TWO: read_reg = perf_mode_two_ctrl;
            `ADDR_PEDESTAL: read_reg = reg_ped;
            `ADDR_OFFS_LOOP: read_reg = reg_loop;
            `ADDR_SLOW_RATE: read_reg = reg_slow;
            default: read_reg = 8'h00;
        endcase
    endfunction

    // serial pins sampled twice, serial clock a third time for edge detect; only s2 and later are looked at
    always_ff @(posedge ref_clk) begin
        clk_s1 <= serial_clk;
        clk_s2 <= clk_s1;
        clk_s3 <= clk_s2;
        sel_s1 <= serial_select_n;
        sel_s2 <= sel_s1;
        dat_s1 <= serial_data_pin;
        dat_s2 <= dat_s1;
    end

    wire sclk_fall = clk_s3 & ~clk_s2;

    // shift 16-bit words msb first; excess partial word dropped
    always_comb begin
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        wr_stb = 1'b0;
        wr_word = {shift, dat_s2};
        next_rd_shift = rd_shift;
        if (sel_s2) begin
            next_bit_cnt = 4'h0;
        end else if (sclk_fall) begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_shift = {shift[13:0], dat_s2};
            next_rd_shift = {rd_shift[6:0], 1'b0};
            if (bit_cnt == 4'h7) begin
                next_rd_shift = read_reg({shift[6:0], dat_s2});
            end
            if (bit_cnt == 4'hF) begin
                wr_stb = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            bit_cnt <= 4'h0;
            shift <= 15'h0000;
            rd_shift <= 8'h00;
        end else begin
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            rd_shift <= next_rd_shift;
        end
    end

    wire [7:0] wa = wr_word[15:8];
    wire [7:0] wd = wr_word[7:0];
    wire readback_on = soft_reset_and_readback[`BIT_READBACK];
    wire soft_rst = soft_reset_and_readback[`BIT_SOFT_RESET];
    wire wr_ok = wr_stb & (~readback_on | (wa == `ADDR_SOFT_RESET));

    // register writes: whole byte stored at once, except 00h which keeps only bits 1:0
    always_ff @(posedge ref_clk) begin
        if (!reset_n || soft_rst) begin
            soft_reset_and_readback <= `REG_RESET_VALUE;
            output_swing_ctrl <= `REG_RESET_VALUE;
            perf_mode_one_ctrl <= `REG_RESET_VALUE;
            gain_and_pattern_ctrl <= `REG_RESET_VALUE;
            output_drive_strength <= `REG_RESET_VALUE;
            format_and_offset_ctrl <= `REG_RESET_VALUE;
            custom_word_high <= `REG_RESET_VALUE;
            custom_word_low <= `REG_RESET_VALUE;
            reg_if <= `REG_RESET_VALUE;
            reg_fall <= `REG_RESET_VALUE;
            reg_pdn <= `REG_RESET_VALUE;
            perf_mode_two_ctrl <= `REG_RESET_VALUE;
            reg_ped <= `REG_RESET_VALUE;
            reg_loop <= `REG_RESET_VALUE;
            reg_slow <= `REG_RESET_VALUE;
        end else if (wr_ok) begin
            // unmapped addresses fall through untouched
            unique case (wa)
                `ADDR_SOFT_RESET: soft_reset_and_readback <= {6'h00, wd[1:0]};
                `ADDR_SWING: output_swing_ctrl <= wd;
                `ADDR_PERF_ONE: perf_mode_one_ctrl <= wd;
                `ADDR_GAIN_PAT: gain_and_pattern_ctrl <= wd;
                `ADDR_DRIVE: output_drive_strength <= wd;
                `ADDR_FORMAT: format_and_offset_ctrl <= wd;
                `ADDR_CUSTOM_HI: custom_word_high <= wd;
                `ADDR_CUSTOM_LO: custom_word_low <= wd;
                `ADDR_IF_RISE: reg_if <= wd;
                `ADDR_FALL_STBY: reg_fall <= wd;
                `ADDR_PDN: reg_pdn <= wd;
                `ADDR_PERF_TWO: perf_mode_two_ctrl <= wd;
                `ADDR_PEDESTAL: reg_ped <= wd;
                `ADDR_OFFS_LOOP: reg_loop <= wd;
                `ADDR_SLOW_RATE: reg_slow <= wd;
                default: ;
            endcase
        end
    end

    assign fast_path_disable = reg_fall[3];
    assign swing_override_enable = reg_pdn[1] & reg_pdn[0];

    // pattern generator; ramp and toggle run every sample
    always_comb begin
        next_ramp_div = ramp_div + 2'h1;
        next_ramp_val = ramp_val;
        if (ramp_div == 2'(`RAMP_DIV - 1)) begin
            next_ramp_val = ramp_val + 12'h001;
        end
        next_toggle_ph = ~toggle_ph;
        unique case (adc_cfg_pkg::pattern_e'(gain_and_pattern_ctrl[2:0]))
            adc_cfg_pkg::pat_normal: next_sample = conv_data;
            adc_cfg_pkg::pat_zeros: next_sample = 12'h000;
            adc_cfg_pkg::pat_ones: next_sample = 12'hFFF;
            adc_cfg_pkg::pat_toggle:
                next_sample = toggle_ph ? `TOGGLE_B : `TOGGLE_A;
            adc_cfg_pkg::pat_ramp: next_sample = ramp_val;
            adc_cfg_pkg::pat_custom:
                next_sample = {custom_word_high,
                               custom_word_low[7:4]};
            default: next_sample = conv_data; // unused codes
        endcase
    end

    // output selections; the flops below only register them
    always_comb begin
        next_pin = readback_on ? rd_shift[7] : overvoltage;
        next_swing = swing_override_enable ? output_swing_ctrl[7:2]
                                           : `SWING_DEFAULT;
        next_gain_active = ~gain_and_pattern_ctrl[3]
                           & fast_path_disable;
        unique case (format_and_offset_ctrl[7:6])
            `FMT_TWOS: next_twos = 1'b1;
            `FMT_OFFSET: next_twos = 1'b0;
            default: next_twos = format_strap_pin;
        endcase
    end

    // outputs all registered; overvoltage is passed with one delay
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ramp_div <= 2'h0;
            ramp_val <= 12'h000;
            toggle_ph <= 1'b0;
            sample_out <= 12'h000;
            overrange_readback_pin <= 1'b0;
            swing_code <= `SWING_DEFAULT;
            clock_driver_double <= 1'b0;
            data_driver_double <= 1'b0;
            gain_code <= 4'h0;
            gain_active <= 1'b0;
            twos_complement <= 1'b0;
            perf_boost_one <= 2'h0;
            perf_boost_two <= 1'b0;
            interface_and_clock_rise <= 8'h00;
            clock_fall_and_standby <= 8'h00;
            power_down_ctrl <= 8'h00;
            offset_pedestal_ctrl <= 8'h00;
            offset_loop_ctrl <= 8'h00;
            slow_rate_ctrl <= 8'h00;
        end else begin
            ramp_div <= next_ramp_div;
            ramp_val <= next_ramp_val;
            toggle_ph <= next_toggle_ph;
            sample_out <= next_sample;
            overrange_readback_pin <= next_pin;
            swing_code <= next_swing;
            clock_driver_double <= output_drive_strength[1];
            data_driver_double <= output_drive_strength[0];
            gain_code <= gain_and_pattern_ctrl[7:4];
            gain_active <= next_gain_active;
            twos_complement <= next_twos;
            perf_boost_one <= perf_mode_one_ctrl[1:0];
            perf_boost_two <= perf_mode_two_ctrl[0];
            interface_and_clock_rise <= reg_if;
            clock_fall_and_standby <= reg_fall;
            power_down_ctrl <= reg_pdn;
            offset_pedestal_ctrl <= reg_ped;
            offset_loop_ctrl <= reg_loop;
            slow_rate_ctrl <= reg_slow;
        end
    end

    // checks
    a_soft_reset_clear: assert property (@(posedge ref_clk)
        disable iff (!reset_n) soft_rst |=> (output_swing_ctrl == 8'h00
        && !soft_reset_and_readback[`BIT_SOFT_RESET]))
        else $error("soft reset did not clear registers");
    // any word not aimed at 00h must leave swing, drive and gain/pattern registers alone in readback
    a_readback_blocks: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (readback_on && wr_stb && !soft_rst
        && wa != `ADDR_SOFT_RESET) |=> $stable({output_swing_ctrl,
        output_drive_strength, gain_and_pattern_ctrl}))
        else $error("write got through in readback mode");
    a_swing_default: assert property (@(posedge ref_clk)
        disable iff (!reset_n) !swing_override_enable
        |=> swing_code == `SWING_DEFAULT)
        else $error("swing code leaked without override");
    a_swing_apply: assert property (@(posedge ref_clk)
        disable iff (!reset_n) swing_override_enable
        |=> swing_code == $past(output_swing_ctrl[7:2]))
        else $error("swing code not applied");
    a_pin_select: assert property (@(posedge ref_clk)
        disable iff (!reset_n) !readback_on
        |=> overrange_readback_pin == $past(overvoltage))
        else $error("pin not showing overvoltage");
    a_readback_pin: assert property (@(posedge ref_clk)
        disable iff (!reset_n) readback_on
        |=> overrange_readback_pin == $past(rd_shift[7]))
        else $error("pin not showing readback data");
    a_toggle_pattern: assert property (@(posedge ref_clk)
        disable iff (!reset_n || soft_rst) (gain_and_pattern_ctrl[2:0]
        == 3'h3)[*2] |-> sample_out != $past(sample_out))
        else $error("toggle pattern did not alternate");
    a_ramp_step: assert property (@(posedge ref_clk)
        disable iff (!reset_n) (gain_and_pattern_ctrl[2:0] == 3'h4
        && ramp_div == 2'h3) |=> ramp_val == $past(ramp_val) + 12'h001)
        else $error("ramp step wrong");
    a_custom_word: assert property (@(posedge ref_clk)
        disable iff (!reset_n) gain_and_pattern_ctrl[2:0] == 3'h5
        |=> sample_out == {$past(custom_word_high),
        $past(custom_word_low[7:4])})
        else $error("custom pattern mismatch");
    a_zero_pattern: assert property (@(posedge ref_clk)
        disable iff (!reset_n) gain_and_pattern_ctrl[2:0] == 3'h1
        |=> sample_out == '0)
        else $error("zeros pattern wrong");
    a_ones_pattern: assert property (@(posedge ref_clk)
        disable iff (!reset_n) gain_and_pattern_ctrl[2:0] == 3'h2
        |=> sample_out == '1)
        else $error("ones pattern wrong");
    a_gain_enable: assert property (@(posedge ref_clk)
        disable iff (!reset_n) gain_and_pattern_ctrl[3]
        |=> !gain_active)
        else $error("gain active while bypassed");
    a_gain_code: assert property (@(posedge ref_clk)
        disable iff (!reset_n) 1'b1
        |=> gain_code == $past(gain_and_pattern_ctrl[7:4]))
        else $error("gain code not copied");
    a_drive_copy: assert property (@(posedge ref_clk)
        disable iff (!reset_n) 1'b1 |=> {clock_driver_double,
        data_driver_double} == $past(output_drive_strength[1:0]))
        else $error("drive strength bits not copied");
    a_format_force: assert property (@(posedge ref_clk)
        disable iff (!reset_n) format_and_offset_ctrl[7:6] == `FMT_TWOS
        |=> twos_complement)
        else $error("twos complement not forced");
    a_word_strobe: assert property (@(posedge ref_clk)
        disable iff (!reset_n || soft_rst) (wr_ok && wa == `ADDR_DRIVE)
        |=> output_drive_strength == $past(wd))
        else $error("drive register missed a whole word");
    c_write: cover property (@(posedge ref_clk) wr_ok);
    c_toggle: cover property (@(posedge ref_clk)
        gain_and_pattern_ctrl[2:0] == 3'h3);
    c_readback: cover property (@(posedge ref_clk) readback_on && wr_stb);
    c_soft: cover property (@(posedge ref_clk) soft_rst);
    c_ramp: cover property (@(posedge ref_clk) ramp_val == 12'hFFF);
endmodule // adc_config_register_bank

// ### serial_ctrl_model.sv
`timescale 1ns/1ns
// external controller: one word of nbits (up to 16) per call, idle clock high
module serial_ctrl_model (
    input wire logic ref_clk,
    output logic serial_clk,
    output logic serial_select_n,
    output logic serial_data_pin,
    input wire logic overrange_readback_pin
);
    localparam int HALF = 8; // slow phases keep the oversampler happy
    logic [7:0] rd_byte;

    initial begin
        serial_clk = 1'b1;
        serial_select_n = 1'b1;
        serial_data_pin = 1'b0;
        rd_byte = 8'h00;
    end

    // nbits below 16 makes a partial word; last drops select
    task automatic send_word(input logic [7:0] a, input logic [7:0] d,
                             input bit last, input int nbits);
        logic [15:0] w;
        w = {a, d};
        @(negedge ref_clk);
        serial_select_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            serial_data_pin <= w[15-i];
            repeat (HALF) @(negedge ref_clk);
            if (i >= 8) rd_byte[15-i] = overrange_readback_pin;
            serial_clk <= 1'b0;
            repeat (HALF) @(negedge ref_clk);
            serial_clk <= 1'b1;
        end
        repeat (HALF) @(negedge ref_clk);
        // released line shows the inverse so stale data never matches
        if (last) begin
            serial_select_n <= 1'b1;
            serial_data_pin <= ~serial_data_pin;
        end
    endtask
endmodule // serial_ctrl_model

// ### testbench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end \
end
module testbench;
    logic ref_clk, reset_n, serial_clk, serial_select_n, serial_data_pin;
    logic overvoltage, format_strap_pin, overrange_readback_pin;
    logic [11:0] conv_data, sample_out, prev;
    logic [5:0] swing_code;
    logic clock_driver_double, data_driver_double, gain_active;
    logic twos_complement, perf_boost_two;
    logic [3:0] gain_code;
    logic [1:0] perf_boost_one;
    logic [7:0] if_rise, fall_stby, pdn, pedestal, offs_loop, slow_rate;
    logic [64:0] bank_bits, snap;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int changes;
    logic [5:0] swing_tab [6] = '{6'h00, 6'h1B, 6'h32, 6'h14, 6'h3E, 6'h0F};
    logic [2:0] pat_tab [4] = '{3'h1, 3'h2, 3'h0, 3'h6};
    logic [11:0] pat_exp [4] = '{12'h000, 12'hFFF, 12'h3C5, 12'h3C5};

    // every register-driven output except the sample path and the overrange/readback pin
    assign bank_bits = {swing_code, clock_driver_double, data_driver_double,
        gain_code, gain_active, twos_complement, perf_boost_one,
        perf_boost_two, if_rise, fall_stby, pdn, pedestal, offs_loop,
        slow_rate};

    adc_config_register_bank dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .serial_clk(serial_clk),
        .serial_select_n(serial_select_n),
        .serial_data_pin(serial_data_pin), .overvoltage(overvoltage),
        .format_strap_pin(format_strap_pin), .conv_data(conv_data),
        .overrange_readback_pin(overrange_readback_pin),
        .sample_out(sample_out), .swing_code(swing_code),
        .clock_driver_double(clock_driver_double),
        .data_driver_double(data_driver_double), .gain_code(gain_code),
        .gain_active(gain_active), .twos_complement(twos_complement),
        .perf_boost_one(perf_boost_one), .perf_boost_two(perf_boost_two),
        .interface_and_clock_rise(if_rise),
        .clock_fall_and_standby(fall_stby), .power_down_ctrl(pdn),
        .offset_pedestal_ctrl(pedestal), .offset_loop_ctrl(offs_loop),
        .slow_rate_ctrl(slow_rate));

    serial_ctrl_model ctrl (
        .ref_clk(ref_clk), .serial_clk(serial_clk),
        .serial_select_n(serial_select_n),
        .serial_data_pin(serial_data_pin),
        .overrange_readback_pin(overrange_readback_pin));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // hang guard, roughly three and a half times the expected run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            end_of_test();
        end
    end

    task end_of_test;
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // settle time covers oversampler plus two register stages
    task wr(input logic [7:0] a, input logic [7:0] d);
        ctrl.send_word(a, d, 1'b1, 16);
        repeat (8) @(negedge ref_clk);
    endtask

    initial begin
        reset_n = 1'b0;
        overvoltage = 1'b0;
        format_strap_pin = 1'b0;
        conv_data = 12'h3C5;
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        `CHK("reset bank", 65'h0, bank_bits)
        // reserved bits always written as zero
        wr(8'h41, 8'hA5);
        wr(8'hBF, 8'h70);
        wr(8'hCF, 8'hBC);
        wr(8'hDF, 8'h30);
        wr(8'h42, 8'hCC);
        `CHK("if_rise", 8'hA5, if_rise)
        `CHK("pedestal", 8'h70, pedestal)
        `CHK("offs_loop", 8'hBC, offs_loop)
        `CHK("slow_rate", 8'h30, slow_rate)
        `CHK("fall_stby", 8'hCC, fall_stby)
        // two words in one select-low frame
        ctrl.send_word(8'h26, 8'h03, 1'b0, 16);
        ctrl.send_word(8'h03, 8'h03, 1'b1, 16);
        wr(8'h4A, 8'h01);
        `CHK("clk drv", 1'b1, clock_driver_double)
        `CHK("data drv", 1'b1, data_driver_double)
        `CHK("boost one", 2'h3, perf_boost_one)
        `CHK("boost two", 1'b1, perf_boost_two)
        // a partial word must be dropped
        ctrl.send_word(8'h26, 8'h00, 1'b1, 8);
        repeat (8) @(negedge ref_clk);
        `CHK("partial", 1'b1, data_driver_double)
        wr(8'h01, 8'hF8);
        `CHK("swing off", 6'h00, swing_code)
        wr(8'h43, 8'h03);
        `CHK("pdn", 8'h03, pdn)
        for (int i = 0; i < 6; i++) begin
            wr(8'h01, {swing_tab[i], 2'b00});
            `CHK("swing", swing_tab[i], swing_code)
        end
        wr(8'h25, 8'hC0);
        `CHK("gain code", 4'hC, gain_code)
        `CHK("gain on", 1'b1, gain_active)
        wr(8'h42, 8'hC4);
        `CHK("gain fast", 1'b0, gain_active)
        wr(8'h42, 8'hCC);
        wr(8'h25, 8'hC8);
        `CHK("gain bypass", 1'b0, gain_active)
        for (int i = 0; i < 4; i++) begin
            wr(8'h25, {5'h00, pat_tab[i]});
            `CHK("pattern", pat_exp[i], sample_out)
        end
        wr(8'h3F, 8'hAB);
        wr(8'h40, 8'hC0);
        wr(8'h25, 8'h05);
        `CHK("custom", 12'hABC, sample_out)
        wr(8'h25, 8'h03);
        for (int i = 0; i < 8; i++) begin
            prev = sample_out;
            @(negedge ref_clk);
            `CHK("toggle", 12'hFFF, sample_out ^ prev)
            `CHK("tog val", 1'b1, sample_out inside {12'h555, 12'hAAA})
        end
        wr(8'h25, 8'h04);
        changes = 0;
        for (int i = 0; i < 16; i++) begin
            prev = sample_out;
            @(negedge ref_clk);
            if (sample_out !== prev) begin
                changes++;
                `CHK("ramp step", prev + 12'h001, sample_out)
            end
        end
        `CHK("ramp rate", 4, changes)
        wr(8'h3D, 8'h80);
        `CHK("fmt twos", 1'b1, twos_complement)
        wr(8'h3D, 8'hC0);
        `CHK("fmt offset", 1'b0, twos_complement)
        wr(8'h3D, 8'h00);
        format_strap_pin = 1'b1;
        repeat (4) @(negedge ref_clk);
        `CHK("fmt strap", 1'b1, twos_complement)
        format_strap_pin = 1'b0;
        overvoltage = 1'b1;
        repeat (4) @(negedge ref_clk);
        `CHK("ovr pin", 1'b1, overrange_readback_pin)
        overvoltage = 1'b0;
        // readback mode: data shown, other writes blocked
        wr(8'h00, 8'h01);
        ctrl.send_word(8'h26, 8'h00, 1'b1, 16);
        repeat (8) @(negedge ref_clk);
        `CHK("readback", 8'h03, ctrl.rd_byte)
        `CHK("blocked", 1'b1, data_driver_double)
        wr(8'h00, 8'h00);
        wr(8'h26, 8'h00);
        `CHK("unblocked", 1'b0, data_driver_double)
        snap = bank_bits;
        wr(8'h02, 8'hFF);
        wr(8'h44, 8'hFF);
        `CHK("unmapped", snap, bank_bits)
        wr(8'h00, 8'h02);
        `CHK("soft reset", 65'h0, bank_bits)
        wr(8'h26, 8'h01);
        `CHK("after reset", 1'b1, data_driver_double)
        end_of_test();
    end
endmodule // testbench
